// >>> design/bsh_pkg.sv
// Purpose: Shared constants and types of the barrel shifter datapath
// Assumes: 16-bit data words, 32-bit shift result, 8-bit signed scale
// Notes:   Codes below are the operation and source selects seen by the core
package bsh_pkg;
    localparam int DW = 16;                         // Data word width
    localparam int RW = 32;                         // Result width
    localparam int SW = 8;                          // Scale and immediate width
    localparam int BW = 5;                          // Block scale width

    // Operation selects
    typedef enum logic [2:0] {
        SIGN_FILL_SHIFT_OP    = 3'h0,
        ZERO_FILL_SHIFT_OP    = 3'h1,
        MANTISSA_ALIGN_OP     = 3'h2,
        DERIVE_SCALE_OP       = 3'h3,
        BLOCK_SCALE_ADJUST_OP = 3'h4
    } bsh_op_t;

    // Input source selects
    typedef enum logic [2:0] {
        SRC_SHIFT_IN  = 3'h0,
        SRC_ALU       = 3'h1,
        SRC_MAC0      = 3'h2,
        SRC_MAC1      = 3'h3,
        SRC_MAC2      = 3'h4,
        SRC_RES_LOW   = 3'h5,
        SRC_RES_HIGH  = 3'h6
    } bsh_src_t;

    localparam logic [RW-1:0] RESULT_RST    = 32'h0000_0000;
    localparam logic [SW-1:0] SCALE_RST     = 8'h00;
    localparam logic [BW-1:0] BLOCK_RST     = 5'h10;        // Minus sixteen
    localparam logic [SW-1:0] SCALE_ALL_SGN = 8'hF1;        // Minus fifteen
    localparam logic [BW-1:0] BLOCK_MIN_HIT = 5'h11;        // Minus fifteen
    localparam logic [DW-1:0] HALF_ZERO     = 16'h0000;
    localparam logic [8:0]    FULL_OUT      = 9'h020;       // Shift of thirty-two
    localparam logic [4:0]    DN_BASE       = 5'h0F;        // Low-half exponent offset
endpackage : bsh_pkg

// >>> design/bsh_barrel_shifter.sv
// Purpose: Barrel shifter with scale derivation and block scale tracking
// Assumes: One op per cycle, results registered on the next clock edge
// Notes:   Core loads of the scale registers lose to an op writing them
// What this block does
// - Five ops: sign-fill shift, zero-fill shift, align, derive scale, block adjust.
// - Overwrite modifier replaces result register with the 32-bit shifted value.
// - Merge modifier ORs shifted value into current result register contents.
// - Top-half ref puts input in upper half, bottom-half ref in lower half.
// - Input from shift-in, ALU, three MAC words or either result half.
// - Block adjust loads block scale only when new exponent is strictly greater.
// - Block scale ends between minus fifteen and zero after adjustments.
// - Block adjust only inspects input; no shift, no result write.
// - Immediate shift uses 8-bit signed field; positive left, negative right.
// - Immediate shift neither reads nor changes shift scale register.
// - Right shifts fill with sign for sign-fill, zeros for zero-fill.
// - Denormalizing shifts take their signed amount from shift scale register.
// - Derive scale detects exponent into shift scale, top or bottom ref.
// - Align moves rightmost sign bit to field MSB; exponent is non-positive.
// - Align shifts by negated shift scale; supports all modifiers.
// - Bottom-half derive changes shift scale only when it holds minus fifteen.
// - Single align goes to upper word for top ref, lower for bottom.
// - Scale below minus fifteen aligns top-ref input fully out of the upper half.
module bsh_barrel_shifter (
    input  wire  logic                clk,
    input  wire  logic                nrst,
    input  wire  logic                op_valid,
    input  wire  bsh_pkg::bsh_op_t    op_code,
    input  wire  bsh_pkg::bsh_src_t   src_sel,
    input  wire  logic                top_half_ref,
    input  wire  logic                merge,
    input  wire  logic                use_imm,
    input  wire  logic [7:0]          imm_amt,
    input  wire  logic [15:0]         shift_in_reg,
    input  wire  logic [15:0]         alu_result_reg,
    input  wire  logic [15:0]         mac_result_word0,
    input  wire  logic [15:0]         mac_result_word1,
    input  wire  logic [15:0]         mac_result_word2,
    input  wire  logic                scale_load,
    input  wire  logic [7:0]          scale_wdata,
    input  wire  logic                block_load,
    input  wire  logic [4:0]          block_wdata,
    output logic [31:0]               shift_result_reg,
    output logic [7:0]                shift_scale_reg,
    output logic [4:0]                block_scale_reg
);
    import bsh_pkg::*;

    logic [DW-1:0] din;
    logic [RW-1:0] placed;
    logic [RW-1:0] shifted;
    logic [SW-1:0] amt;
    logic [8:0]    mag;
    logic          arith;
    logic          is_shift;
    logic [DW-2:0] run_up;
    logic [DW-1:0] run_dn;
    logic [4:0]    cnt_up;
    logic [4:0]    cnt_dn;
    logic [SW-1:0] scl_up;
    logic [SW-1:0] scl_dn;
    logic [SW-1:0] scl_det;
    logic          up_sign;
    logic [RW-1:0] next_shift_result_reg;
    logic [SW-1:0] next_shift_scale_reg;
    logic [BW-1:0] next_block_scale_reg;
    logic          next_up_sign;

    ////////////////////////////////////////////////////////////////////////////
    // Input source mux; result halves allow reshifting a prior result
    always_comb begin
        case (src_sel)
            SRC_SHIFT_IN: din = shift_in_reg;
            SRC_ALU:      din = alu_result_reg;
            SRC_MAC0:     din = mac_result_word0;
            SRC_MAC1:     din = mac_result_word1;
            SRC_MAC2:     din = mac_result_word2;
            SRC_RES_LOW:  din = shift_result_reg[DW-1:0];
            SRC_RES_HIGH: din = shift_result_reg[RW-1:DW];
            default:      din = shift_in_reg;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sign run chains for exponent detection, one stage per bit
    genvar gi;
    generate
        for (gi = 0; gi < DW - 1; gi++) begin : g_run
            if (gi == DW - 2) begin : g_top
                assign run_up[gi]   = (din[gi] == din[DW-1]);
                assign run_dn[gi+1] = (din[gi+1] == up_sign);
            end else begin : g_mid
                assign run_up[gi]   = run_up[gi+1] & (din[gi] == din[DW-1]);
                assign run_dn[gi+1] = run_dn[gi+2] & (din[gi+1] == up_sign);
            end
        end
    endgenerate
    assign run_dn[0] = run_dn[1] & (din[0] == up_sign);

    // Count redundant sign bits; all-sign upper half gives minus fifteen
    always_comb begin
        cnt_up = 5'h00;
        cnt_dn = 5'h00;
        for (int i = 0; i < DW - 1; i++) begin
            cnt_up = cnt_up + 5'(run_up[i]);
        end
        for (int i = 0; i < DW; i++) begin
            cnt_dn = cnt_dn + 5'(run_dn[i]);
        end
        scl_up  = SW'(-$signed({3'h0, cnt_up}));
        // Lower half carries on the count below minus fifteen
        scl_dn  = SW'(-$signed({3'h0, cnt_dn + DN_BASE}));
        scl_det = top_half_ref ? scl_up : scl_dn;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Placement, amount and fill selection, then the shift itself
    always_comb begin
        is_shift = (op_code == SIGN_FILL_SHIFT_OP) || (op_code == ZERO_FILL_SHIFT_OP)
                 || (op_code == MANTISSA_ALIGN_OP);
        arith    = (op_code == SIGN_FILL_SHIFT_OP)
                 || ((op_code == MANTISSA_ALIGN_OP) && top_half_ref);
        // Bottom ref extends with sign only for sign-fill shifts
        if (top_half_ref) begin
            placed = {din, HALF_ZERO};
        end else if (op_code == SIGN_FILL_SHIFT_OP) begin
            placed = {{DW{din[DW-1]}}, din};
        end else begin
            placed = {HALF_ZERO, din};
        end
        // Align negates scale so a negative exponent shifts left
        if (op_code == MANTISSA_ALIGN_OP) begin
            amt = SW'(-$signed(shift_scale_reg));
        end else if (use_imm) begin
            amt = imm_amt;
        end else begin
            amt = shift_scale_reg;
        end
        // Nine bits hold a magnitude of one hundred twenty-eight
        mag = amt[SW-1] ? 9'(-$signed({amt[SW-1], amt})) : {1'b0, amt};
        if (mag >= FULL_OUT) begin
            shifted = (amt[SW-1] && arith) ? {RW{placed[RW-1]}} : RESULT_RST;
        end else if (!amt[SW-1]) begin
            shifted = placed << mag[4:0];
        end else if (arith) begin
            shifted = RW'($signed(placed) >>> mag[4:0]);
        end else begin
            shifted = placed >> mag[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the result, scale, block scale and stored sign
    always_comb begin
        next_shift_result_reg = shift_result_reg;
        next_shift_scale_reg  = shift_scale_reg;
        next_block_scale_reg  = block_scale_reg;
        next_up_sign          = up_sign;
        if (scale_load) begin
            next_shift_scale_reg = scale_wdata;
        end
        if (block_load) begin
            next_block_scale_reg = block_wdata;
        end
        if (op_valid) begin
            case (op_code)
                SIGN_FILL_SHIFT_OP, ZERO_FILL_SHIFT_OP, MANTISSA_ALIGN_OP: begin
                    if (merge) begin
                        next_shift_result_reg = shift_result_reg | shifted;
                    end else begin
                        next_shift_result_reg = shifted;
                    end
                end
                DERIVE_SCALE_OP: begin
                    if (top_half_ref) begin
                        next_shift_scale_reg = scl_det;
                        next_up_sign         = din[DW-1];
                    end else if (shift_scale_reg == SCALE_ALL_SGN) begin
                        next_shift_scale_reg = scl_det;
                    end
                end
                BLOCK_SCALE_ADJUST_OP: begin
                    // Strict compare keeps the first winner on ties
                    if ($signed(scl_up[BW-1:0]) > $signed(block_scale_reg)) begin
                        next_block_scale_reg = scl_up[BW-1:0];
                    end
                end
                default: begin
                    next_shift_result_reg = shift_result_reg;
                end
            endcase
        end
    end

    // State registers, synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            shift_result_reg <= RESULT_RST;
            shift_scale_reg  <= SCALE_RST;
            block_scale_reg  <= BLOCK_RST;
            up_sign          <= 1'b0;
        end else begin
            shift_result_reg <= next_shift_result_reg;
            shift_scale_reg  <= next_shift_scale_reg;
            block_scale_reg  <= next_block_scale_reg;
            up_sign          <= next_up_sign;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the registered results
    AST_OVERWRITE: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && is_shift && !merge) |=> (shift_result_reg == $past(shifted)))
        else $error("overwrite result mismatch");

    AST_MERGE: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && is_shift && merge)
        |=> (shift_result_reg == ($past(shift_result_reg) | $past(shifted))))
        else $error("merge result mismatch");

    AST_ADJ_INSPECT: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == BLOCK_SCALE_ADJUST_OP && !scale_load)
        |=> ($stable(shift_result_reg) && $stable(shift_scale_reg)))
        else $error("block adjust touched result or scale");

    AST_ADJ_LOAD: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == BLOCK_SCALE_ADJUST_OP
         && $signed(scl_up[BW-1:0]) > $signed(block_scale_reg))
        |=> (block_scale_reg == $past(scl_up[BW-1:0])))
        else $error("block scale not loaded");

    AST_ADJ_RANGE: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == BLOCK_SCALE_ADJUST_OP && !block_load)
        |=> ($signed(block_scale_reg) >= $signed(BLOCK_MIN_HIT)
             && $signed(block_scale_reg) <= 0))
        else $error("block scale out of range");

    AST_IMM_SCALE: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && use_imm && op_code != MANTISSA_ALIGN_OP && is_shift && !scale_load)
        |=> $stable(shift_scale_reg))
        else $error("immediate shift changed scale");

    AST_DN_DERIVE: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == DERIVE_SCALE_OP && !top_half_ref
         && shift_scale_reg != SCALE_ALL_SGN && !scale_load)
        |=> $stable(shift_scale_reg))
        else $error("bottom derive altered scale");

    AST_UP_DERIVE: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == DERIVE_SCALE_OP && top_half_ref)
        |=> (shift_scale_reg == $past(scl_up) && $signed(shift_scale_reg) <= 0))
        else $error("top derive wrong exponent");

    AST_FULL_OUT: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == ZERO_FILL_SHIFT_OP && use_imm && !merge
         && ($signed(imm_amt) <= -32 || $signed(imm_amt) >= 32))
        |=> (shift_result_reg == RESULT_RST))
        else $error("large shift left input bits");

    AST_OFF_SCALE: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == MANTISSA_ALIGN_OP && top_half_ref && !merge
         && $signed(shift_scale_reg) < -15)
        |=> (shift_result_reg[RW-1:DW] == HALF_ZERO))
        else $error("upper half not cleared");

    // Reset, bottom derive range, block keep, core load and fill bits; the reset check runs during reset
    AST_RST_VALUES: assert property (@(posedge clk)
        !nrst |=> (shift_result_reg == RESULT_RST && shift_scale_reg == SCALE_RST
                   && block_scale_reg == BLOCK_RST))
        else $error("reset values not restored");

    AST_DN_LOAD: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == DERIVE_SCALE_OP && !top_half_ref && shift_scale_reg == SCALE_ALL_SGN)
        |=> ($signed(shift_scale_reg) <= -15 && $signed(shift_scale_reg) >= -31))
        else $error("bottom derive exponent out of range");

    AST_ADJ_KEEP: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == BLOCK_SCALE_ADJUST_OP && !block_load
         && $signed(scl_up[BW-1:0]) <= $signed(block_scale_reg))
        |=> $stable(block_scale_reg))
        else $error("block scale loaded without a larger exponent");

    AST_CORE_LOAD: assert property (@(posedge clk) disable iff (!nrst)
        (scale_load && !(op_valid && op_code == DERIVE_SCALE_OP))
        |=> (shift_scale_reg == $past(scale_wdata)))
        else $error("core scale load lost");

    AST_ZERO_FILL: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == ZERO_FILL_SHIFT_OP && use_imm && !merge && imm_amt[SW-1])
        |=> (shift_result_reg[RW-1] == 1'b0))
        else $error("zero-fill shift brought in ones");

    AST_SIGN_FILL: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && op_code == SIGN_FILL_SHIFT_OP && use_imm && !merge && imm_amt[SW-1])
        |=> (shift_result_reg[RW-1] == $past(din[DW-1])))
        else $error("sign-fill shift lost the sign");

    AST_LEFT_FILL: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && is_shift && op_code != MANTISSA_ALIGN_OP && use_imm && !merge
         && !imm_amt[SW-1] && imm_amt != 8'h00)
        |=> (shift_result_reg[0] == 1'b0))
        else $error("left shift did not fill with zero");

endmodule : bsh_barrel_shifter

// >>> tb/bsh_core_model.sv
// Purpose: Core register file model feeding the shifter data inputs
// Assumes: One write per cycle, value visible after the writing edge
// Notes:   Result-half selects are not held here, so writes to them are dropped
module bsh_core_model (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              wr_en,
    input  wire bsh_pkg::bsh_src_t wr_sel,
    input  wire logic [15:0]       wr_data,
    output logic [15:0]            shift_in_reg,
    output logic [15:0]            alu_result_reg,
    output logic [15:0]            mac_result_word0,
    output logic [15:0]            mac_result_word1,
    output logic [15:0]            mac_result_word2
);
    timeunit 1ns;
    timeprecision 1ps;
    import bsh_pkg::*;
    logic [15:0] regs [5];
    logic [15:0] next_regs [5];

    ////////////////////////////////////////////////////////////////////////////
    // Next values: only the five data registers are writable
    always_comb begin
        next_regs = regs;
        if (wr_en && wr_sel < SRC_RES_LOW) begin
            next_regs[wr_sel] = wr_data;
        end
    end

    // Registers; odd reset pattern so a missed load never reads as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regs <= '{16'h5A5A, 16'hA5A5, 16'h5A5A, 16'hA5A5, 16'h5A5A};
        end else begin
            regs <= next_regs;
        end
    end

    assign shift_in_reg     = regs[0];
    assign alu_result_reg   = regs[1];
    assign mac_result_word0 = regs[2];
    assign mac_result_word1 = regs[3];
    assign mac_result_word2 = regs[4];
endmodule : bsh_core_model

// >>> tb/tb_barrel_shifter_ops.sv
// Purpose: Self-checking bench for the barrel shifter datapath
// Assumes: One-cycle result latency, inputs driven by NBA at rising edges
// Notes:   Expected words worked out by hand from the shift and scale rules
module tb_barrel_shifter_ops;
    timeunit 1ns;
    timeprecision 1ps;
    import bsh_pkg::*;
    logic clk = 0, nrst = 0, op_valid = 0, top = 0, mrg = 0, use_imm = 0;
    logic wr_en = 0, scale_load = 0, block_load = 0;
    bsh_op_t op_code = SIGN_FILL_SHIFT_OP;
    bsh_src_t src_sel = SRC_SHIFT_IN;
    bsh_src_t wr_sel = SRC_SHIFT_IN;
    logic [7:0] imm_amt = 8'h00, scale_wdata = 8'h00;
    logic [4:0] block_wdata = 5'h00;
    logic [15:0] wr_data = 16'h0000, si, alu, m0, m1, m2;
    logic [31:0] res;
    logic [7:0] scl;
    logic [4:0] blk;
    int fail_count = 0, n_tests = 0;

    always #50 clk = ~clk;

    bsh_core_model i_core (.clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
        .shift_in_reg(si), .alu_result_reg(alu), .mac_result_word0(m0), .mac_result_word1(m1),
        .mac_result_word2(m2));
    bsh_barrel_shifter i_dut (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
        .src_sel(src_sel), .top_half_ref(top), .merge(mrg), .use_imm(use_imm), .imm_amt(imm_amt),
        .shift_in_reg(si), .alu_result_reg(alu), .mac_result_word0(m0), .mac_result_word1(m1),
        .mac_result_word2(m2), .scale_load(scale_load), .scale_wdata(scale_wdata),
        .block_load(block_load), .block_wdata(block_wdata), .shift_result_reg(res),
        .shift_scale_reg(scl), .block_scale_reg(blk));

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk

    // Core writes the source word first, then issues one op
    task automatic run(input bsh_op_t oc, input bsh_src_t s, input logic t, input logic m,
                       input logic u, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en    <= 1'b1;
        wr_sel   <= s;
        wr_data  <= d;
        @(posedge clk);
        wr_en    <= 1'b0;
        op_valid <= 1'b1;
        op_code  <= oc;
        src_sel  <= s;
        top      <= t;
        mrg      <= m;
        use_imm  <= u;
        imm_amt  <= a;
        @(posedge clk);
        op_valid <= 1'b0;
        #10;
    endtask : run

    task automatic ld(input logic se, input logic [7:0] sv, input logic be, input logic [4:0] bv);
        @(posedge clk);
        scale_load  <= se;
        scale_wdata <= sv;
        block_load  <= be;
        block_wdata <= bv;
        @(posedge clk);
        scale_load  <= 1'b0;
        block_load  <= 1'b0;
        #10;
    endtask : ld

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_imm();
        bsh_op_t  oc[7] = '{SIGN_FILL_SHIFT_OP, ZERO_FILL_SHIFT_OP, ZERO_FILL_SHIFT_OP, SIGN_FILL_SHIFT_OP,
                            SIGN_FILL_SHIFT_OP, ZERO_FILL_SHIFT_OP, SIGN_FILL_SHIFT_OP};
        bsh_src_t sr[7] = '{SRC_SHIFT_IN, SRC_ALU, SRC_MAC0, SRC_MAC1, SRC_MAC2, SRC_SHIFT_IN, SRC_ALU};
        logic       tp[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [7:0] am[7] = '{8'hFB, 8'hFB, 8'h05, 8'h05, 8'hE0, 8'h20, 8'hFD};
        logic [31:0] ex[7] = '{32'hFDB5_1800, 32'h05B5_1800, 32'h0016_D460, 32'hFFF6_D460,
                               32'hFFFF_FFFF, 32'h0000_0000, 32'hFFFF_F6D4};
        ld(1'b1, 8'h05, 1'b0, 5'h00);
        for (int i = 0; i < 7; i++) begin
            run(oc[i], sr[i], tp[i], 1'b0, 1'b1, am[i], 16'hB6A3);
            chk(res, ex[i]);
        end
        chk({24'h0, scl}, 32'h0000_0005);
    endtask : t_imm

    // Double word denormalise, upper half first then lower
    task automatic t_denorm();
        ld(1'b1, 8'hFD, 1'b0, 5'h00);
        run(SIGN_FILL_SHIFT_OP, SRC_MAC0, 1'b1, 1'b0, 1'b0, 8'h00, 16'hB6A3);
        chk(res, 32'hF6D4_6000);
        run(ZERO_FILL_SHIFT_OP, SRC_ALU, 1'b0, 1'b1, 1'b0, 8'h00, 16'h765D);
        chk(res, 32'hF6D4_6ECB);
    endtask : t_denorm

    task automatic t_align();
        run(DERIVE_SCALE_OP, SRC_SHIFT_IN, 1'b1, 1'b0, 1'b0, 8'h00, 16'hF6D4);
        chk({24'h0, scl}, 32'h0000_00FD);
        run(DERIVE_SCALE_OP, SRC_SHIFT_IN, 1'b0, 1'b0, 1'b0, 8'h00, 16'h6ECB);
        chk({24'h0, scl}, 32'h0000_00FD);
        run(MANTISSA_ALIGN_OP, SRC_MAC2, 1'b1, 1'b0, 1'b0, 8'h00, 16'hF6D4);
        chk(res, 32'hB6A0_0000);
        run(MANTISSA_ALIGN_OP, SRC_MAC1, 1'b0, 1'b1, 1'b0, 8'h00, 16'h6ECB);
        chk(res, 32'hB6A3_7658);
        run(ZERO_FILL_SHIFT_OP, SRC_RES_LOW, 1'b1, 1'b0, 1'b1, 8'h00, 16'h0000);
        chk(res, 32'h7658_0000);
        run(ZERO_FILL_SHIFT_OP, SRC_RES_HIGH, 1'b0, 1'b1, 1'b1, 8'hF8, 16'h0000);
        chk(res, 32'h7658_0076);
    endtask : t_align

    // Upper half all sign bits: lower derive takes over the scale
    task automatic t_allsign();
        run(DERIVE_SCALE_OP, SRC_SHIFT_IN, 1'b1, 1'b0, 1'b0, 8'h00, 16'hFFFF);
        chk({24'h0, scl}, 32'h0000_00F1);
        run(DERIVE_SCALE_OP, SRC_ALU, 1'b0, 1'b0, 1'b0, 8'h00, 16'hF6D4);
        chk({24'h0, scl}, 32'h0000_00ED);
        run(MANTISSA_ALIGN_OP, SRC_SHIFT_IN, 1'b1, 1'b0, 1'b0, 8'h00, 16'hFFFF);
        chk(res, 32'h0000_0000);
        run(MANTISSA_ALIGN_OP, SRC_ALU, 1'b0, 1'b1, 1'b0, 8'h00, 16'hF6D4);
        chk(res, 32'hB6A0_0000);
    endtask : t_allsign

    task automatic t_block();
        logic [15:0] din[5] = '{16'hF5B1, 16'h0100, 16'h4000, 16'hC000, 16'h7FFF};
        logic [4:0]  ex[5]  = '{5'h1D, 5'h1D, 5'h00, 5'h00, 5'h00};
        ld(1'b0, 8'h00, 1'b1, 5'h10);
        for (int i = 0; i < 5; i++) begin
            run(BLOCK_SCALE_ADJUST_OP, SRC_MAC0, 1'b1, 1'b0, 1'b0, 8'h00, din[i]);
            chk({27'h0, blk}, {27'h0, ex[i]});
        end
        chk(res, 32'hB6A0_0000);
        chk({24'h0, scl}, 32'h0000_00ED);
    endtask : t_block

    // Mid-run reset restores every register; an op and an undecoded code follow
    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #10;
        chk(res, 32'h0000_0000);
        chk({16'h0, scl, 3'h0, blk}, {16'h0, 8'h00, 3'h0, 5'h10});
        run(DERIVE_SCALE_OP, SRC_SHIFT_IN, 1'b1, 1'b0, 1'b0, 8'h00, 16'h0040);
        chk({24'h0, scl}, 32'h0000_00F8);
        run(bsh_op_t'(3'h5), SRC_SHIFT_IN, 1'b1, 1'b0, 1'b1, 8'h00, 16'hFFFF);
        chk(res, 32'h0000_0000);
        chk({24'h0, scl}, 32'h0000_00F8);
    endtask : t_reset

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and run control
    task automatic stop_test();
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // Watchdog so a stalled sequence still reaches the verdict
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        #10;
        chk(res, 32'h0000_0000);
        chk({16'h0, scl, 3'h0, blk}, {16'h0, 8'h00, 3'h0, 5'h10});
        t_imm();
        t_denorm();
        t_align();
        t_allsign();
        t_block();
        t_reset();
        stop_test();
    end
endmodule : tb_barrel_shifter_ops
